// ===== include/sps_params.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define SPS_IDX_CTRL     6'h0D
`define SPS_IDX_STAT     6'h0E
`define SPS_IDX_DATA     6'h0F
`define SPS_IDX_EVST     6'h10
`define SPS_IDX_EVMASK   6'h11
`define SPS_IDX_PINCFG   6'h12

// ****************************************
// Field positions
// ****************************************
`define SPS_CTRL_IRQEN   7
`define SPS_CTRL_EN      6
`define SPS_CTRL_LSBF    5
`define SPS_CTRL_CONTROLLER_SELECT    4
`define SPS_CTRL_CPOL    3
`define SPS_CTRL_CPHA    2
`define SPS_EV_DONE      0
`define SPS_EV_WRITE_COLLISION_FLAG      1
`define SPS_PIN_SSIN     0
`define SPS_PIN_SSLVL    1

// ****************************************
// Reset values
// ****************************************
`define SPS_CTRL_RST     8'h00
`define SPS_PINCFG_RST   2'b11
`define SPS_SYNC_RST     4'b1000

// ****************************************
// Timing: clock dividers and shortest serial clock period
// ****************************************
`define SPS_DIV_N0       8'd4
`define SPS_DIV_N1       8'd16
`define SPS_DIV_N2       8'd64
`define SPS_DIV_N3       8'd128
`define SPS_DIV_D0       8'd2
`define SPS_DIV_D1       8'd8
`define SPS_DIV_D2       8'd32
`define SPS_DIV_D3       8'd64
`define SPS_CLK_NS       10
`define SPS_SCK_MIN_NS   20
`define SPS_SCK_MIN_CYC  ((`SPS_SCK_MIN_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)

`endif

// ===== include/sps_pkg.sv
// Types shared by the serial port design
package sps_pkg;
	typedef enum logic [1:0] {
		SPS_IDLE = 2'b00,
		SPS_CTRL = 2'b01,
		SPS_TGT  = 2'b10
	} sps_state_t;
	typedef logic [7:0] sps_byte_t;
endpackage : sps_pkg

// ===== verilog/sps_port.sv
// Serial peripheral port: status, data and rate logic behind an AHB-Lite slave
// ****************************************
// What this block does
// - Each finished byte sets the done flag and raises the request when both enables are set.
// - A low select pin while controller with select as input also sets the done flag.
// - Entering the interrupt handler clears the done flag.
// - Reading status with done set, then touching the data register, clears done.
// - Writing the data register mid-transfer sets the collision flag.
// - Reading status with collision set, then touching data, clears collision and done.
// - Status bits five to one always read zero.
// - Double rate bit doubles the controller serial clock.
// - Shortest controller serial clock period is two system clocks.
// - Writing the data register while idle loads the shifter and, as controller, starts the byte.
// - Reading the data register returns the receive buffer.
// - Controller clock divides by 4,16,64,128 or 2,8,32,64 when doubled; targets ignore it.
// - Select pulled low while controller drops controller mode until software sets it again.
// - Controller clock starts on a data write and stops after exactly one byte, or earlier when a select fault drops controller mode.
// - Transmit is single buffered; a received byte is lost if not read before the next completes.
// ****************************************
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "sps_params.svh"

module sps_port (
	input  wire logic              core_clk,        // System clock
	input  wire logic              rst_n,           // Synchronous reset
	input  wire logic              hsel,            // Slave select
	input  wire logic [31:0]       haddr,           // Address
	input  wire logic [1:0]        htrans,          // Transfer type
	input  wire logic              hwrite,          // Write
	input  wire logic [2:0]        hsize,           // Size, word only
	input  wire logic [31:0]       hwdata,          // Write data
	input  wire logic              hready,          // Bus ready
	output logic [31:0]            hrdata,          // Read data
	output logic                   hreadyout,       // Always ready
	output logic                   hresp,           // Always OKAY
	input  wire logic              global_irq_en,   // CPU global interrupt enable
	input  wire logic              irq_ack,         // Handler vector taken
	output logic                   xfer_irq_req,    // Port interrupt request
	output logic                   irq,             // Masked event interrupt
	input  wire logic              sck_i,           // Serial clock in
	output logic                   sck_o,           // Serial clock out
	output logic                   sck_oe,          // Serial clock drive
	input  wire logic              mosi_i,          // Controller out in
	output logic                   mosi_o,          // Controller out
	output logic                   mosi_oe,         // Controller out drive
	input  wire logic              miso_i,          // Target out in
	output logic                   miso_o,          // Target out
	output logic                   miso_oe,         // Target out drive
	input  wire logic              ss_n_i,          // Select pin in
	output logic                   ss_n_o,          // Select pin out
	output logic                   ss_n_oe          // Select pin drive
);
	import sps_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] sy1, sy2, sy3, filt, filt_q;
	wire  [3:0] pins_in = {ss_n_i, miso_i, mosi_i, sck_i};
	localparam logic [3:0] sync_rst_val = `SPS_SYNC_RST;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					sy1[gi]    <= sync_rst_val[gi];
					sy2[gi]    <= sync_rst_val[gi];
					sy3[gi]    <= sync_rst_val[gi];
					filt[gi]   <= sync_rst_val[gi];
					filt_q[gi] <= sync_rst_val[gi];
				end else begin
					sy1[gi]    <= pins_in[gi];
					sy2[gi]    <= sy1[gi];
					sy3[gi]    <= sy2[gi];
					// Glitch shorter than a cycle never counts
					filt[gi]   <= (sy2[gi] == sy3[gi]) ? sy3[gi] : filt[gi];
					filt_q[gi] <= filt[gi];
				end
			end
		end
	endgenerate

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0]  ctrl;
	logic [1:0]  pincfg;
	logic        dbl;
	logic        done_f, write_collision_flag_f, arm_done, arm_write_collision_flag;
	logic [1:0]  ev, ev_mask;
	sps_byte_t   sh, rx_buf;
	logic        out_bit;
	sps_state_t  state;
	logic [5:0]  div_cnt;
	logic [4:0]  edge_cnt;
	logic [3:0]  bit_cnt;
	logic        sck_q;
	logic        wr_q;
	logic [5:0]  addr_q;

	// ****************************************
	// Bus decode
	// ****************************************
	wire       addr_ph   = hsel & htrans[1] & hready;
	wire [5:0] idx       = haddr[7:2];
	wire       rd_take   = addr_ph & ~hwrite;
	wire       rd_stat   = rd_take & (idx == `SPS_IDX_STAT);
	wire       rd_data   = rd_take & (idx == `SPS_IDX_DATA);
	wire       wr_ctrl   = wr_q & (addr_q == `SPS_IDX_CTRL);
	wire       wr_stat   = wr_q & (addr_q == `SPS_IDX_STAT);
	wire       wr_data   = wr_q & (addr_q == `SPS_IDX_DATA);
	wire       wr_evst   = wr_q & (addr_q == `SPS_IDX_EVST);
	wire       wr_evmask = wr_q & (addr_q == `SPS_IDX_EVMASK);
	wire       wr_pincfg = wr_q & (addr_q == `SPS_IDX_PINCFG);
	wire       data_acc  = rd_data | wr_data;

	// ****************************************
	// Mode and clock selection
	// ****************************************
	wire enabled    = ctrl[`SPS_CTRL_EN];
	wire controller_select       = ctrl[`SPS_CTRL_CONTROLLER_SELECT];
	wire cpol       = ctrl[`SPS_CTRL_CPOL];
	wire cpha       = ctrl[`SPS_CTRL_CPHA];
	wire lsbf       = ctrl[`SPS_CTRL_LSBF];
	wire busy       = (state != SPS_IDLE);
	wire mode_fault = enabled & controller_select & pincfg[`SPS_PIN_SSIN] & ~filt[3];

	function automatic logic [5:0] half_cnt(input logic d, input logic [1:0] r);
		logic [7:0] dv;
		dv = 8'd0;
		case ({d, r})
			3'b000:  dv = `SPS_DIV_N0;
			3'b001:  dv = `SPS_DIV_N1;
			3'b010:  dv = `SPS_DIV_N2;
			3'b011:  dv = `SPS_DIV_N3;
			3'b100:  dv = `SPS_DIV_D0;
			3'b101:  dv = `SPS_DIV_D1;
			3'b110:  dv = `SPS_DIV_D2;
			default: dv = `SPS_DIV_D3;
		endcase
		half_cnt = 6'((dv >> 1) - 8'd1);
	endfunction : half_cnt

	wire [5:0] half_m1 = half_cnt(dbl, ctrl[1:0]);
	wire       c_tick  = (state == SPS_CTRL) & (div_cnt == 6'd0);
	wire       c_last  = c_tick & (edge_cnt == 5'd15);

	// Target edges come only from the filtered pin, hence the quarter-rate limit
	wire t_sel   = enabled & ~controller_select & ~filt[3];
	wire t_chg   = t_sel & (filt[0] ^ filt_q[0]);
	wire t_lead  = t_chg & (filt[0] != cpol);
	wire t_trail = t_chg & (filt[0] == cpol);
	wire lead    = (state == SPS_CTRL) ? (c_tick & ~edge_cnt[0]) : t_lead;
	wire trail   = (state == SPS_CTRL) ? (c_tick & edge_cnt[0]) : t_trail;
	wire smp_ev  = cpha ? trail : lead;
	wire shf_ev  = cpha ? lead : trail;
	wire in_bit  = controller_select ? filt[2] : filt[1];
	wire tx_top  = lsbf ? sh[0] : sh[7];
	wire [7:0] next_sh = lsbf ? {in_bit, sh[7:1]} : {sh[6:0], in_bit};
	wire rx_load = smp_ev & (bit_cnt == 4'd7);
	// Target entry edge shifts too, or cpha 0 would lose the first bit
	wire shift_act = busy | t_chg;
	wire done_ev = (state == SPS_CTRL) ? c_last : ((state == SPS_TGT) & rx_load);
	wire done_set = done_ev | mode_fault;
	wire write_collision_flag_set = wr_data & busy;
	wire start_c  = wr_data & ~busy & enabled & controller_select & ~mode_fault;

	// ****************************************
	// Control and configuration registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl    <= `SPS_CTRL_RST;
			dbl     <= 1'b0;
			pincfg  <= `SPS_PINCFG_RST;
			ev_mask <= 2'b00;
		end else begin
			if (mode_fault)
				ctrl <= ctrl & ~(8'h01 << `SPS_CTRL_CONTROLLER_SELECT);
			else if (wr_ctrl)
				ctrl <= hwdata[7:0];
			if (wr_stat)
				dbl <= hwdata[0];
			if (wr_pincfg)
				pincfg <= hwdata[1:0];
			if (wr_evmask)
				ev_mask <= hwdata[1:0];
		end
	end

	// ****************************************
	// Flags: set wins over every clear
	// ****************************************
	wire clr_by_seq_d = data_acc & (arm_done | arm_write_collision_flag);
	wire clr_by_seq_w = data_acc & arm_write_collision_flag;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			done_f   <= 1'b0;
			write_collision_flag_f   <= 1'b0;
			arm_done <= 1'b0;
			arm_write_collision_flag <= 1'b0;
			ev       <= 2'b00;
		end else begin
			done_f   <= done_set | (done_f & ~irq_ack & ~clr_by_seq_d);
			write_collision_flag_f   <= write_collision_flag_set | (write_collision_flag_f & ~clr_by_seq_w);
			arm_done <= rd_stat ? done_f : (arm_done & ~data_acc);
			arm_write_collision_flag <= rd_stat ? write_collision_flag_f : (arm_write_collision_flag & ~data_acc);
			ev       <= {write_collision_flag_set, done_set} | (ev & ~({2{wr_evst}} & hwdata[1:0]));
		end
	end

	// ****************************************
	// Shift engine
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state    <= SPS_IDLE;
			sh       <= 8'h00;
			rx_buf   <= 8'h00;
			out_bit  <= 1'b0;
			div_cnt  <= 6'd0;
			edge_cnt <= 5'd0;
			bit_cnt  <= 4'd0;
			sck_q    <= 1'b0;
		end else begin
			case (state)
				SPS_IDLE: begin
					sck_q    <= cpol;
					edge_cnt <= 5'd0;
					bit_cnt  <= 4'd0;
					div_cnt  <= half_m1;
					if (wr_data)
						sh <= hwdata[7:0];
					out_bit <= wr_data ? (lsbf ? hwdata[0] : hwdata[7]) : tx_top;
					if (start_c)
						state <= SPS_CTRL;
					else if (t_lead | t_trail)
						state <= SPS_TGT;
				end
				SPS_CTRL: begin
					div_cnt <= c_tick ? half_m1 : div_cnt - 6'd1;
					if (c_tick) begin
						sck_q    <= ~sck_q;
						edge_cnt <= edge_cnt + 5'd1;
					end
					if (mode_fault || c_last)
						state <= SPS_IDLE;
				end
				SPS_TGT: begin
					if (filt[3] || !enabled || controller_select)
						state <= SPS_IDLE;
					else if (rx_load)
						state <= SPS_IDLE;
				end
				default: state <= SPS_IDLE;
			endcase
			// Colliding writes never reach the shifter: sh only loads from IDLE
			if (shift_act && shf_ev)
				out_bit <= tx_top;
			if (shift_act && smp_ev) begin
				sh      <= next_sh;
				bit_cnt <= bit_cnt + 4'd1;
			end
			if (shift_act && rx_load)
				rx_buf <= next_sh;
		end
	end

	// ****************************************
	// Bus slave: zero wait states, read data registered at address phase
	// ****************************************
	logic [31:0] rd_mux;
	assign rd_mux = (idx == `SPS_IDX_CTRL)   ? {24'h0000_00, ctrl} :
	                (idx == `SPS_IDX_STAT)   ? {24'h0000_00, done_f, write_collision_flag_f, 5'b0_0000, dbl} :
	                (idx == `SPS_IDX_DATA)   ? {24'h0000_00, rx_buf} :
	                (idx == `SPS_IDX_EVST)   ? {30'h0000_0000, ev} :
	                (idx == `SPS_IDX_EVMASK) ? {30'h0000_0000, ev_mask} :
	                (idx == `SPS_IDX_PINCFG) ? {30'h0000_0000, pincfg} : 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_q     <= 1'b0;
			addr_q   <= 6'd0;
			hrdata   <= 32'h0000_0000;
		end else begin
			wr_q     <= addr_ph & hwrite;
			addr_q   <= idx;
			if (rd_take)
				hrdata <= rd_mux;
		end
	end

	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign irq          = |(ev & ev_mask);
	assign xfer_irq_req = done_f & ctrl[`SPS_CTRL_IRQEN] & global_irq_en;

	// ****************************************
	// Pins
	// ****************************************
	assign sck_o   = (state == SPS_CTRL) ? sck_q : cpol;
	assign sck_oe  = enabled & controller_select;
	assign mosi_o  = out_bit;
	assign mosi_oe = enabled & controller_select;
	assign miso_o  = out_bit;
	assign miso_oe = t_sel;
	assign ss_n_o  = pincfg[`SPS_PIN_SSLVL];
	assign ss_n_oe = enabled & controller_select & ~pincfg[`SPS_PIN_SSIN];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_done_ctrl_end: assert property (c_last |=> done_f)
		else $error("done flag not set after last controller edge");
	a_fault_drop_controller_select: assert property (mode_fault |=> !ctrl[`SPS_CTRL_CONTROLLER_SELECT] && done_f && state == SPS_IDLE)
		else $error("select fault did not drop controller mode");
	a_ack_clears: assert property (irq_ack && !done_set |=> !done_f)
		else $error("done flag survived handler entry");
	a_seq_clears: assert property (arm_write_collision_flag && data_acc && !done_set && !write_collision_flag_set |=> !done_f && !write_collision_flag_f)
		else $error("status then data access did not clear flags");
	a_write_collision_flag_busy_write: assert property (wr_data && busy |=> write_collision_flag_f && ($stable(state) || state == SPS_IDLE))
		else $error("collision not flagged");
	a_discard_write: assert property (wr_data && busy && !smp_ev |=> sh == $past(sh))
		else $error("colliding write disturbed the shifter");
	a_rsvd_zero: assert property (rd_stat |=> hrdata[5:1] == 5'b0_0000)
		else $error("reserved status bits not zero");
	a_rx_read: assert property (rd_data |=> hrdata[7:0] == $past(rx_buf))
		else $error("data read did not return receive buffer");
	a_start_write: assert property (start_c |=> state == SPS_CTRL && sh == $past(hwdata[7:0]))
		else $error("data write did not start controller transfer");
	a_fast_rate: assert property (c_tick && !c_last && {dbl, ctrl[1:0]} == 3'b100 |=> c_tick)
		else $error("doubled fastest rate not two clocks per period");
	a_slow_rate: assert property (c_tick && !c_last && {dbl, ctrl[1:0]} == 3'b000 |=> !c_tick ##1 c_tick)
		else $error("normal fastest rate not four clocks per period");
	a_period_min: assert property (state == SPS_CTRL && $past(state) == SPS_CTRL && $changed(sck_o)
		|-> $past(c_tick))
		else $error("serial clock moved without a divider tick");

	c_ctrl_done: cover property (c_last);
	c_tgt_done: cover property (state == SPS_TGT && rx_load);
	c_collision: cover property (write_collision_flag_set);
	c_mode_fault: cover property (mode_fault);

endmodule : sps_port

// ===== verification/sps_tgt_model.sv
// Behavioural serial target that answers the port when it runs as controller
`timescale 1ns/100ps

module sps_tgt_model (
	input  wire logic       sck,     // Serial clock from controller
	input  wire logic       mosi,    // Data from controller
	input  wire logic       sel_n,   // Target select, active low
	input  wire logic [7:0] tx_byte, // Byte sent back
	output logic            miso,    // Data to controller
	output logic [7:0]      rx_byte  // Byte received
);
	logic [7:0] shf;

	initial miso = 1'b1;
	// Mode 0: first bit ready at select, sample rising, shift falling
	always @(negedge sel_n) begin
		shf = tx_byte;
		miso = tx_byte[7];
	end
	always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
	always @(negedge sck) if (!sel_n) begin
		shf = {shf[6:0], 1'b0};
		miso <= shf[7];
	end
	// Released line flips so a stale bit never looks valid
	always @(posedge sel_n) miso = ~miso;
endmodule : sps_tgt_model

// ===== verification/sps_port_tb.sv
// Self-checking bench for the serial port status, data and rate logic
`timescale 1ns/100ps
`include "sps_params.svh"

module sps_port_tb;
	logic        core_clk, rst_n, hsel, hwrite, hresp, hreadyout, global_irq_en, irq_ack, xfer_irq_req, irq;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, miso_t, ss_in_n, tgt_sel_n;
	logic        prev_sck, ext_sck, ext_mosi;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  tgt_rx, got;
	localparam logic [7:0] tgt_tx = 8'hC3;
	int          miscompares, compares, tog, gap, half;
	int          divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	wire logic   hready = hreadyout;
	// Pin levels taken from the port when its drive enable is set, otherwise from the bench
	wire logic   sck_i = sck_oe ? sck_o : ext_sck;
	wire logic   mosi_i = mosi_oe ? mosi_o : ext_mosi;
	wire logic   miso_i = miso_oe ? miso_o : miso_t;
	wire logic   ss_n_i = ss_n_oe ? ss_n_o : ss_in_n;

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	sps_port sps_port_inst (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .global_irq_en, .irq_ack, .xfer_irq_req, .irq, .sck_i, .sck_o, .sck_oe,
		.mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .ss_n_o, .ss_n_oe);
	sps_tgt_model sps_tgt_model_inst (.sck(sck_i), .mosi(mosi_i), .sel_n(tgt_sel_n), .tx_byte(8'h96),
		.miso(miso_t), .rx_byte(tgt_rx));

	// Off-edge sampling keeps the toggle count free of races
	always @(negedge core_clk) begin
		if (sck_o !== prev_sck) begin
			tog++;
			half = gap;
			gap = 1;
		end else
			gap++;
		prev_sck = sck_o;
	end

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0000_00, idx, 2'b00};
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		rdv = hrdata;
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d, rd);
	endtask : wr

	task automatic rcheck(input string what, input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0000_0000, rd);
		chk(what, rd, exp);
	endtask : rcheck

	// Polling reads also arm the flag clear
	task automatic wait_done();
		rd = 32'h0000_0000;
		for (int k = 0; k < 600 && rd[7] !== 1'b1; k++) bus(1'b0, `SPS_IDX_STAT, 32'h0000_0000, rd);
	endtask : wait_done

	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		global_irq_en = 1'b1;
		irq_ack = 1'b0;
		ss_in_n = 1'b1;
		tgt_sel_n = 1'b1;
		ext_sck = 1'b0;
		ext_mosi = 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rcheck("ctrl", `SPS_IDX_CTRL, 32'h0000_0000);
		rcheck("status", `SPS_IDX_STAT, 32'h0000_0000);
		rcheck("pincfg", `SPS_IDX_PINCFG, 32'h0000_0003);
		rcheck("unmapped", 6'h3F, 32'h0000_0000);
		wr(`SPS_IDX_STAT, 32'h0000_00FF);
		rcheck("status reserved", `SPS_IDX_STAT, 32'h0000_0001);
		$display("test reset done");
		wr(`SPS_IDX_CTRL, 32'h0000_00D2);
		tgt_sel_n <= 1'b0;
		wr(`SPS_IDX_DATA, 32'h0000_00A5);
		wr(`SPS_IDX_DATA, 32'h0000_005A);
		wait_done();
		@(negedge core_clk);
		chk("status flags", rd, 32'h0000_00C1);
		chk("port request", {31'h0, xfer_irq_req}, 32'h0000_0001);
		chk("event irq", {31'h0, irq}, 32'h0000_0000);
		wr(`SPS_IDX_EVMASK, 32'h0000_0001);
		@(negedge core_clk);
		chk("event irq", {31'h0, irq}, 32'h0000_0001);
		@(posedge core_clk);
		irq_ack <= 1'b1;
		@(posedge core_clk);
		irq_ack <= 1'b0;
		rcheck("status ack", `SPS_IDX_STAT, 32'h0000_0041);
		chk("port request", {31'h0, xfer_irq_req}, 32'h0000_0000);
		rcheck("rx data", `SPS_IDX_DATA, 32'h0000_0096);
		rcheck("status clear", `SPS_IDX_STAT, 32'h0000_0001);
		chk("target rx", {24'h0, tgt_rx}, 32'h0000_00A5);
		wr(`SPS_IDX_EVST, 32'h0000_0003);
		@(negedge core_clk);
		chk("event irq", {31'h0, irq}, 32'h0000_0000);
		tgt_sel_n <= 1'b1;
		$display("test collision done");
		for (int i = 0; i < 8; i++) begin
			wr(`SPS_IDX_STAT, {31'h0, i[2]});
			wr(`SPS_IDX_CTRL, {24'h0, 6'b010100, i[1:0]});
			tgt_sel_n <= 1'b0;
			tog = 0;
			wr(`SPS_IDX_DATA, i);
			wait_done();
			chk("toggles", tog, 16);
			chk("half period", half, divs[i] / 2);
			chk("target rx", {24'h0, tgt_rx}, i);
			bus(1'b0, `SPS_IDX_DATA, 32'h0000_0000, rd);
			if (divs[i] >= 16) chk("rx data", rd, 32'h0000_0096);
			rcheck("status cleared", `SPS_IDX_STAT, {31'h0, i[2]});
			tgt_sel_n <= 1'b1;
		end
		$display("test rates done");
		// Outside controller: half period of six clocks, inside the quarter-rate limit
		wr(`SPS_IDX_CTRL, 32'h0000_0040);
		wr(`SPS_IDX_DATA, 32'h0000_003C);
		ss_in_n <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			ext_sck  <= 1'b0;
			ext_mosi <= tgt_tx[b];
			repeat (5) @(posedge core_clk);
			@(negedge core_clk);
			got = {got[6:0], miso_i};
			@(posedge core_clk);
			ext_sck <= 1'b1;
			repeat (6) @(posedge core_clk);
		end
		ext_sck <= 1'b0;
		ss_in_n <= 1'b1;
		wait_done();
		chk("target status", rd, 32'h0000_0081);
		chk("target tx", {24'h0, got}, 32'h0000_003C);
		rcheck("target rx data", `SPS_IDX_DATA, {24'h0, tgt_tx});
		rcheck("target status cleared", `SPS_IDX_STAT, 32'h0000_0001);
		$display("test target done");
		wr(`SPS_IDX_STAT, 32'h0000_0000);
		wr(`SPS_IDX_CTRL, 32'h0000_0050);
		ss_in_n <= 1'b0;
		wait_done();
		chk("status fault", rd, 32'h0000_0080);
		ss_in_n <= 1'b1;
		rcheck("ctrl fault", `SPS_IDX_CTRL, 32'h0000_0040);
		rcheck("pincfg", `SPS_IDX_PINCFG, 32'h0000_0003);
		wr(`SPS_IDX_CTRL, 32'h0000_0050);
		rcheck("ctrl resume", `SPS_IDX_CTRL, 32'h0000_0050);
		$display("test mode fault done");
		conclude();
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		conclude();
	end
endmodule : sps_port_tb
